// ---- hw/wocfg_top.sv ----
// How it works
// - each option register takes one software write per reset, then holds.
// - trip-mode field is re-armed and cleared by power-on reset only.
// - both registers read back current contents at any time.
// - register two decodes at index 1D, register one at index 1F.
// - reset clears option bits, except those defined as set by reset.
// - rate bit picks watchdog timeout 2^13-16 when set, 2^18-16 when clear.
// - with monitor powered, monitor-in-stop bit keeps it running in stop.
// - monitor reset-disable bit blocks the monitor reset request.
// - monitor power-disable is set by reset and unpowers the monitor.
// - short-recovery bit gives 32 cycle stop exit, else 4096 cycles.
// - leaving stop through reset always uses the long recovery.
// - stop-enable bit lets the stop opcode run, else it is illegal.
// - watchdog disable bit switches the watchdog module off.
// - internal oscillator stop-disable bit halts the rc oscillator in stop.
// - crystal stop-enable bit keeps the crystal running in stop.
// - with crystal clock selected, bypass bit skips the divide-by-two.
// - bypass has no effect with the pll clock selected; reset clears it.
// - port c upper bit gives pins 4 to 7 to frontplanes 23 to 26.
// - port c lower bit gives pins 0 to 3 to frontplanes 19 to 22.
// - trip field picks supply mode: 00 and 11 reserved, 01 3V, 10 5V.
//
// Implementation choice: register access over Wishbone.
module wocfg_top
    import wocfg_pkg::*;
#(
    parameter int unsigned REC_LONG = REC_LONG_CYC,
    parameter int unsigned REC_SHORT = REC_SHORT_CYC
) (
    input wire logic REF_CLK_I, // bus clock
    input wire logic RST_N_I, // any reset, async, active low
    input wire logic POR_N_I, // power-on reset, async, active low
    input wire logic CE_I, // clock enable, freezes state when low
    input wire logic CYC_I, // wishbone cycle
    input wire logic STB_I, // wishbone strobe
    input wire logic WE_I, // wishbone write enable
    input wire logic [WB_ADR_W-1:0] ADR_I, // wishbone byte address
    input wire logic [3:0] SEL_I, // wishbone byte selects
    input wire logic [WB_DAT_W-1:0] DAT_I, // wishbone write data
    output logic [WB_DAT_W-1:0] DAT_O, // wishbone read data
    output logic ACK_O, // wishbone acknowledge
    input wire logic STOP_OPCODE_I, // decoder saw stop opcode, pulse
    input wire logic STOP_WAKE_I, // wake request while stopped, pulse
    input wire logic MON_RESET_REQ_I, // monitor reset request, level
    input wire logic BUS_CLOCK_SELECT_I, // 1 = pll clock selected
    output logic WATCHDOG_DISABLE_O, // watchdog module off
    output logic [WDOG_TO_W-1:0] WATCHDOG_TIMEOUT_O, // timeout cycles
    output logic MON_POWER_EN_O, // monitor powered
    output logic MON_STOP_RUN_O, // monitor runs in stop
    output logic MON_RESET_O, // monitor reset passed on
    output logic [1:0] MON_TRIP_MODE_O, // monitor supply mode
    output logic MON_TRIP_RSVD_O, // trip mode is a reserved code
    output logic STOP_ENTER_O, // stop accepted, pulse
    output logic ILLEGAL_OPCODE_O, // stop refused as illegal, pulse
    output logic STOP_RECOVERING_O, // stop exit delay running
    output logic IRC_STOP_DISABLE_O, // rc oscillator halts in stop
    output logic XTAL_STOP_ENABLE_O, // crystal runs in stop
    output logic DIVIDER_BYPASS_O, // divide-by-two bypassed
    output logic PORT_C_UPPER_LCD_O, // pins 4..7 to frontplanes
    output logic PORT_C_LOWER_LCD_O, // pins 0..3 to frontplanes
    output logic OPT_ONE_USED_O, // register one write spent
    output logic OPT_TWO_USED_O // register two write spent
);
    logic rst_all_n;
    logic req;
    logic take;
    logic wr_lane;
    wocfg_sel_e sel;
    logic [7:0] opt_one;
    logic [7:0] two_gen;
    logic [1:0] trip;
    logic one_used;
    logic two_used;
    logic trip_used;
    logic [7:0] rd_byte;
    logic in_stop_q;
    logic [REC_W-1:0] rec_cnt_q;
    logic stop_take;
    logic wake_take;

    // every reset source clears the general options
    assign rst_all_n = RST_N_I & POR_N_I;

    // register decode on word index
    function automatic wocfg_sel_e decode(input logic [5:0] idx);
        if (idx == OPT_ONE_IDX) begin
            return WOCFG_SEL_ONE;
        end else if (idx == OPT_TWO_IDX) begin
            return WOCFG_SEL_TWO;
        end
        return WOCFG_SEL_NONE;
    endfunction

    // new request, taken once per wishbone cycle
    assign req = CYC_I & STB_I & ~ACK_O;
    assign take = CE_I & req;
    assign wr_lane = take & WE_I & SEL_I[0];
    assign sel = decode(ADR_I[7:2]);

    // readback of both registers, reserved bits as zero
    always_comb begin
        rd_byte = 8'h00;
        unique case (sel)
            WOCFG_SEL_ONE: rd_byte = opt_one & ONE_IMPL_MASK;
            WOCFG_SEL_TWO: rd_byte = two_gen | 8'(trip << TWO_TRIP_LSB);
            WOCFG_SEL_NONE: rd_byte = 8'h00;
        endcase
    end

    // acknowledge one cycle after the request, unmapped too
    always_ff @(posedge REF_CLK_I or negedge rst_all_n) begin
        if (!rst_all_n) begin
            ACK_O <= 1'b0;
        end else if (CE_I) begin
            ACK_O <= req;
        end
    end

    // read data, upper bits zero
    always_ff @(posedge REF_CLK_I or negedge rst_all_n) begin
        if (!rst_all_n) begin
            DAT_O <= 32'h0000_0000;
        end else if (take && !WE_I) begin
            DAT_O <= {24'h00_0000, rd_byte};
        end
    end

    // register one, power-disable set by reset
    wocfg_lock #(
        .W(8),
        .RST_VAL(ONE_RESET)
    ) u_one (
        .clk_i(REF_CLK_I),
        .rst_n_i(rst_all_n),
        .ce_i(CE_I),
        .wr_i(wr_lane && sel == WOCFG_SEL_ONE),
        .wdata_i(DAT_I[7:0] & ONE_IMPL_MASK),
        .q_o(opt_one),
        .used_o(one_used)
    );

    // register two general bits, cleared by any reset
    wocfg_lock #(
        .W(8),
        .RST_VAL(TWO_RESET)
    ) u_two (
        .clk_i(REF_CLK_I),
        .rst_n_i(rst_all_n),
        .ce_i(CE_I),
        .wr_i(wr_lane && sel == WOCFG_SEL_TWO),
        .wdata_i(DAT_I[7:0] & TWO_GEN_MASK),
        .q_o(two_gen),
        .used_o(two_used)
    );

    // trip field, armed and cleared by power-on reset only
    wocfg_lock #(
        .W(2),
        .RST_VAL(TRIP_RESET)
    ) u_trip (
        .clk_i(REF_CLK_I),
        .rst_n_i(POR_N_I),
        .ce_i(CE_I),
        .wr_i(wr_lane && sel == WOCFG_SEL_TWO),
        .wdata_i(DAT_I[TWO_TRIP_LSB+1:TWO_TRIP_LSB]),
        .q_o(trip),
        .used_o(trip_used)
    );

    // watchdog and monitor option outputs
    always_ff @(posedge REF_CLK_I or negedge rst_all_n) begin
        if (!rst_all_n) begin
            WATCHDOG_DISABLE_O <= 1'b0;
            WATCHDOG_TIMEOUT_O <= WDOG_LONG_CYC;
            MON_POWER_EN_O <= 1'b0;
            MON_STOP_RUN_O <= 1'b0;
            MON_RESET_O <= 1'b0;
        end else if (CE_I) begin
            WATCHDOG_DISABLE_O <= opt_one[ONE_WDOG_DIS_BIT];
            WATCHDOG_TIMEOUT_O <= opt_one[ONE_WDOG_RATE_BIT] ?
                WDOG_SHORT_CYC : WDOG_LONG_CYC;
            MON_POWER_EN_O <= ~opt_one[ONE_MON_PWRD_BIT];
            MON_STOP_RUN_O <= ~opt_one[ONE_MON_PWRD_BIT] &
                opt_one[ONE_MON_STOP_BIT];
            MON_RESET_O <= MON_RESET_REQ_I &
                ~opt_one[ONE_MON_RSTD_BIT];
        end
    end

    // trip mode, kept across non power-on resets
    always_ff @(posedge REF_CLK_I or negedge POR_N_I) begin
        if (!POR_N_I) begin
            MON_TRIP_MODE_O <= TRIP_RESET;
            MON_TRIP_RSVD_O <= 1'b1;
        end else if (CE_I) begin
            MON_TRIP_MODE_O <= trip;
            MON_TRIP_RSVD_O <= (trip == TRIP_RSVD_LOW) ||
                (trip == TRIP_RSVD_HIGH);
        end
    end

    // oscillator, clock and pin mux outputs
    always_ff @(posedge REF_CLK_I or negedge rst_all_n) begin
        if (!rst_all_n) begin
            IRC_STOP_DISABLE_O <= 1'b0;
            XTAL_STOP_ENABLE_O <= 1'b0;
            DIVIDER_BYPASS_O <= 1'b0;
            PORT_C_UPPER_LCD_O <= 1'b0;
            PORT_C_LOWER_LCD_O <= 1'b0;
            OPT_ONE_USED_O <= 1'b0;
            OPT_TWO_USED_O <= 1'b0;
        end else if (CE_I) begin
            IRC_STOP_DISABLE_O <= two_gen[TWO_IRC_DIS_BIT];
            XTAL_STOP_ENABLE_O <= two_gen[TWO_XTAL_EN_BIT];
            DIVIDER_BYPASS_O <= two_gen[TWO_BYPASS_BIT] &
                ~BUS_CLOCK_SELECT_I;
            PORT_C_UPPER_LCD_O <= two_gen[TWO_PC_UPPER_BIT];
            PORT_C_LOWER_LCD_O <= two_gen[TWO_PC_LOWER_BIT];
            OPT_ONE_USED_O <= one_used;
            OPT_TWO_USED_O <= two_used;
        end
    end

    // stop opcode handling and stop state
    assign stop_take = CE_I & STOP_OPCODE_I & ~in_stop_q;
    assign wake_take = CE_I & STOP_WAKE_I & in_stop_q;

    always_ff @(posedge REF_CLK_I or negedge rst_all_n) begin
        if (!rst_all_n) begin
            STOP_ENTER_O <= 1'b0;
            ILLEGAL_OPCODE_O <= 1'b0;
        end else if (CE_I) begin
            STOP_ENTER_O <= stop_take & opt_one[ONE_STOP_EN_BIT];
            ILLEGAL_OPCODE_O <= stop_take &
                ~opt_one[ONE_STOP_EN_BIT];
        end
    end

    always_ff @(posedge REF_CLK_I or negedge rst_all_n) begin
        if (!rst_all_n) begin
            in_stop_q <= 1'b0;
        end else if (wake_take) begin
            in_stop_q <= 1'b0;
        end else if (stop_take && opt_one[ONE_STOP_EN_BIT]) begin
            in_stop_q <= 1'b1;
        end
    end

    // stop exit delay; reset release starts the long one
    always_ff @(posedge REF_CLK_I or negedge rst_all_n) begin
        if (!rst_all_n) begin
            rec_cnt_q <= REC_W'(REC_LONG - 1);
            STOP_RECOVERING_O <= 1'b1;
        end else if (wake_take) begin
            rec_cnt_q <= opt_one[ONE_SHORT_REC_BIT] ?
                REC_W'(REC_SHORT - 1) : REC_W'(REC_LONG - 1);
            STOP_RECOVERING_O <= 1'b1;
        end else if (CE_I && STOP_RECOVERING_O) begin
            if (rec_cnt_q == '0) begin
                STOP_RECOVERING_O <= 1'b0;
            end else begin
                rec_cnt_q <= rec_cnt_q - 1'b1;
            end
        end
    end

    // first write to register one lands
    property p_one_first;
        @(posedge REF_CLK_I) disable iff (!rst_all_n)
        wr_lane && sel == WOCFG_SEL_ONE && !one_used |=>
            one_used && opt_one == ($past(DAT_I[7:0]) & ONE_IMPL_MASK);
    endproperty
    a_one_first: assert property (p_one_first)
        else $error("first write to register one not latched");

    // trip field survives later writes until power-on reset
    property p_trip_hold;
        @(posedge REF_CLK_I) disable iff (!POR_N_I)
        trip_used |=> $stable(trip);
    endproperty
    a_trip_hold: assert property (p_trip_hold)
        else $error("trip field changed after its one write");

    // reads return current contents one cycle later
    property p_read_one;
        @(posedge REF_CLK_I) disable iff (!rst_all_n)
        take && !WE_I && sel == WOCFG_SEL_ONE |=>
            ACK_O && DAT_O == {24'h00_0000, $past(opt_one)};
    endproperty
    a_read_one: assert property (p_read_one)
        else $error("register one readback wrong");

    // unmapped reads answer zero
    property p_read_none;
        @(posedge REF_CLK_I) disable iff (!rst_all_n)
        take && !WE_I && sel == WOCFG_SEL_NONE |=>
            ACK_O && DAT_O == 32'h0000_0000;
    endproperty
    a_read_none: assert property (p_read_none)
        else $error("unmapped read not zero");

    // watchdog timeout follows the rate bit
    property p_wdog_rate;
        @(posedge REF_CLK_I) disable iff (!rst_all_n || !CE_I)
        $rose(opt_one[ONE_WDOG_RATE_BIT]) |=>
            WATCHDOG_TIMEOUT_O == WDOG_SHORT_CYC;
    endproperty
    a_wdog_rate: assert property (p_wdog_rate)
        else $error("watchdog timeout not short after rate set");

    // powered-down monitor never runs in stop
    property p_mon_power;
        @(posedge REF_CLK_I) disable iff (!rst_all_n || !CE_I)
        opt_one[ONE_MON_PWRD_BIT] |=> !MON_POWER_EN_O && !MON_STOP_RUN_O;
    endproperty
    a_mon_power: assert property (p_mon_power)
        else $error("monitor powered while power-disable set");

    // reset request blocked by reset-disable
    property p_mon_reset;
        @(posedge REF_CLK_I) disable iff (!rst_all_n || !CE_I)
        opt_one[ONE_MON_RSTD_BIT] |=> !MON_RESET_O;
    endproperty
    a_mon_reset: assert property (p_mon_reset)
        else $error("monitor reset passed while disabled");

    // bypass only with crystal clock selected
    property p_bypass;
        @(posedge REF_CLK_I) disable iff (!rst_all_n || !CE_I)
        BUS_CLOCK_SELECT_I |=> !DIVIDER_BYPASS_O;
    endproperty
    a_bypass: assert property (p_bypass)
        else $error("bypass active with pll clock");

    // stop opcode refused while stop is disabled
    property p_stop_illegal;
        @(posedge REF_CLK_I) disable iff (!rst_all_n)
        stop_take && !opt_one[ONE_STOP_EN_BIT] |=>
            ILLEGAL_OPCODE_O && !STOP_ENTER_O;
    endproperty
    a_stop_illegal: assert property (p_stop_illegal)
        else $error("stop opcode not flagged illegal");

    // short recovery lasts exactly 32 cycles
    property p_short_rec;
        @(posedge REF_CLK_I) disable iff (!rst_all_n || !CE_I)
        wake_take && opt_one[ONE_SHORT_REC_BIT] && REC_SHORT == 32 |=>
            STOP_RECOVERING_O ##31 STOP_RECOVERING_O ##1 !STOP_RECOVERING_O;
    endproperty
    a_short_rec: assert property (p_short_rec)
        else $error("short stop recovery length wrong");

    // long recovery loads the long count
    property p_long_rec;
        @(posedge REF_CLK_I) disable iff (!rst_all_n)
        wake_take && !opt_one[ONE_SHORT_REC_BIT] |=>
            STOP_RECOVERING_O && rec_cnt_q == REC_W'(REC_LONG - 1);
    endproperty
    a_long_rec: assert property (p_long_rec)
        else $error("long stop recovery not loaded");
endmodule

// ---- hw/wocfg_pkg.sv ----
package wocfg_pkg;
    // wishbone geometry, byte address, word index in adr[7:2]
    localparam int unsigned WB_ADR_W = 8;
    localparam int unsigned WB_DAT_W = 32;
    localparam logic [5:0] OPT_TWO_IDX = 6'h1D;
    localparam logic [5:0] OPT_ONE_IDX = 6'h1F;

    // option register one field positions
    localparam int unsigned ONE_WDOG_RATE_BIT = 7;
    localparam int unsigned ONE_MON_STOP_BIT = 6;
    localparam int unsigned ONE_MON_RSTD_BIT = 5;
    localparam int unsigned ONE_MON_PWRD_BIT = 4;
    localparam int unsigned ONE_SHORT_REC_BIT = 2;
    localparam int unsigned ONE_STOP_EN_BIT = 1;
    localparam int unsigned ONE_WDOG_DIS_BIT = 0;
    localparam logic [7:0] ONE_IMPL_MASK = 8'hF7;
    localparam logic [7:0] ONE_RESET = 8'h10;

    // option register two field positions
    localparam int unsigned TWO_IRC_DIS_BIT = 6;
    localparam int unsigned TWO_XTAL_EN_BIT = 5;
    localparam int unsigned TWO_PC_UPPER_BIT = 4;
    localparam int unsigned TWO_PC_LOWER_BIT = 3;
    localparam int unsigned TWO_TRIP_LSB = 1;
    localparam int unsigned TWO_BYPASS_BIT = 0;
    localparam logic [7:0] TWO_GEN_MASK = 8'h79;
    localparam logic [7:0] TWO_RESET = 8'h00;
    localparam logic [1:0] TRIP_RESET = 2'h0;

    // trip mode encodings
    localparam logic [1:0] TRIP_RSVD_LOW = 2'h0;
    localparam logic [1:0] TRIP_3V = 2'h1;
    localparam logic [1:0] TRIP_5V = 2'h2;
    localparam logic [1:0] TRIP_RSVD_HIGH = 2'h3;

    // watchdog timeouts in internal clock cycles
    localparam int unsigned WDOG_TO_W = 18;
    localparam logic [17:0] WDOG_SHORT_CYC = 18'((1 << 13) - (1 << 4));
    localparam logic [17:0] WDOG_LONG_CYC = 18'((1 << 18) - (1 << 4));

    // stop recovery delays in internal clock cycles
    localparam int unsigned REC_SHORT_CYC = 32;
    localparam int unsigned REC_LONG_CYC = 4096;
    localparam int unsigned REC_W = 13;

    // register decode result
    typedef enum logic [1:0] {
        WOCFG_SEL_NONE,
        WOCFG_SEL_ONE,
        WOCFG_SEL_TWO
    } wocfg_sel_e;
endpackage

// ---- hw/wocfg_lock.sv ----
module wocfg_lock
    import wocfg_pkg::*;
#(
    parameter int unsigned W = 8,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic clk_i, // bus clock
    input wire logic rst_n_i, // async reset, active low
    input wire logic ce_i, // clock enable
    input wire logic wr_i, // write strobe, one cycle
    input wire logic [W-1:0] wdata_i, // value to latch
    output logic [W-1:0] q_o, // latched value
    output logic used_o // one-shot write spent
);
    // first write latches, later writes fall on the floor
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            q_o <= RST_VAL;
        end else if (ce_i && wr_i && !used_o) begin
            q_o <= wdata_i;
        end
    end

    // spent flag, only reset re-arms it
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            used_o <= 1'b0;
        end else if (ce_i && wr_i) begin
            used_o <= 1'b1;
        end
    end

    // hold after the one write
    property p_lock_hold;
        @(posedge clk_i) disable iff (!rst_n_i)
        used_o |=> $stable(q_o) && used_o;
    endproperty
    a_lock_hold: assert property (p_lock_hold)
        else $error("latched option changed after its one write");
endmodule

// ---- test/wocfg_bench.sv ----
module wocfg_bench
    import wocfg_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int unsigned LONG = 64;
    localparam logic [7:0] A_ONE = {OPT_ONE_IDX, 2'b00};
    localparam logic [7:0] A_TWO = {OPT_TWO_IDX, 2'b00};
    // design inputs, all given a value at time zero
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic por_n = 1'b0;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'h0;
    logic [31:0] dat_w = 32'h00000000;
    logic opc = 1'b0;
    logic wake = 1'b0;
    logic mreq = 1'b0;
    logic bus_clock_select = 1'b0;
    logic ce = 1'b1;
    logic [31:0] dat_r;
    logic ack, wdog_dis, mon_pwr, mon_stop, mon_rst, trip_rsvd;
    logic stop_enter, illegal, rec, irc, xtal, bypass, pcu, pcl;
    logic one_used, two_used;
    logic [17:0] wdog_to;
    logic [1:0] trip;
    int failures = 0;
    int cmp_count = 0;
    // free-running bus clock
    always #5 ref_clk = ~ref_clk;
    wocfg_top #(.REC_LONG(LONG), .REC_SHORT(REC_SHORT_CYC)) i_dut (
        .REF_CLK_I(ref_clk), .RST_N_I(rst_n), .POR_N_I(por_n),
        .CE_I(ce), .CYC_I(cyc), .STB_I(stb), .WE_I(we), .ADR_I(adr),
        .SEL_I(sel), .DAT_I(dat_w), .DAT_O(dat_r), .ACK_O(ack),
        .STOP_OPCODE_I(opc), .STOP_WAKE_I(wake), .MON_RESET_REQ_I(mreq),
        .BUS_CLOCK_SELECT_I(bus_clock_select), .WATCHDOG_DISABLE_O(wdog_dis),
        .WATCHDOG_TIMEOUT_O(wdog_to), .MON_POWER_EN_O(mon_pwr),
        .MON_STOP_RUN_O(mon_stop), .MON_RESET_O(mon_rst),
        .MON_TRIP_MODE_O(trip), .MON_TRIP_RSVD_O(trip_rsvd),
        .STOP_ENTER_O(stop_enter), .ILLEGAL_OPCODE_O(illegal),
        .STOP_RECOVERING_O(rec), .IRC_STOP_DISABLE_O(irc),
        .XTAL_STOP_ENABLE_O(xtal), .DIVIDER_BYPASS_O(bypass),
        .PORT_C_UPPER_LCD_O(pcu), .PORT_C_LOWER_LCD_O(pcl),
        .OPT_ONE_USED_O(one_used), .OPT_TWO_USED_O(two_used)
    );
    // verdict and end of run
    task summarize;
        $display("compares %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // compare seen against expected
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            failures++;
            $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    task tick(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    // one classic wishbone cycle, request held until ack is sampled
    task xfer(input logic [7:0] a, input logic w, input logic [7:0] d,
              input logic [3:0] s, output logic [31:0] r);
        int n;
        n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= s;
        dat_w <= {24'h000000, d};
        @(posedge ref_clk);
        while (ack !== 1'b1 && n < 20) begin
            @(posedge ref_clk);
            n++;
        end
        if (n == 20) begin
            failures++;
            summarize();
        end
        r = dat_r;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        @(posedge ref_clk);
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] r;
        xfer(a, 1'b1, d, 4'hF, r);
    endtask
    task rd(input logic [7:0] a, input logic [7:0] exp);
        logic [31:0] r;
        xfer(a, 1'b0, 8'h00, 4'hF, r);
        chk(r, {24'h000000, exp});
    endtask
    // reset pulse, por selects power-on reset as well
    task rst(input logic por);
        rst_n <= 1'b0;
        por_n <= ~por;
        tick(2);
        rst_n <= 1'b1;
        por_n <= 1'b1;
        tick(1);
    endtask
    // bounded wait for the stop exit delay to end
    task wait_low;
        int n;
        n = 0;
        while (rec !== 1'b0 && n < 200) begin
            @(negedge ref_clk);
            n++;
        end
        if (n == 200) begin
            failures++;
            summarize();
        end
        @(posedge ref_clk);
    endtask
    // stop opcode pulse, count the two result pulses
    task stop_try(input logic ok);
        int e, i;
        e = 0;
        i = 0;
        opc <= 1'b1;
        @(posedge ref_clk);
        opc <= 1'b0;
        repeat (4) begin
            @(negedge ref_clk);
            e += (stop_enter === 1'b1) ? 1 : 0;
            i += (illegal === 1'b1) ? 1 : 0;
        end
        chk(32'(e), {31'h0, ok});
        chk(32'(i), {31'h0, ~ok});
        @(posedge ref_clk);
    endtask
    // wake pulse in stop, measure recovery length in cycles
    task wake_len(input int exp);
        int n, k;
        n = 0;
        k = 0;
        wake <= 1'b1;
        @(posedge ref_clk);
        wake <= 1'b0;
        while (rec !== 1'b1 && k < 5) begin
            @(negedge ref_clk);
            k++;
        end
        while (rec === 1'b1 && n < 5000) begin
            @(negedge ref_clk);
            n++;
        end
        chk(32'(n), 32'(exp));
        @(posedge ref_clk);
    endtask
    // hang guard
    initial begin
        repeat (100000) @(posedge ref_clk);
        failures++;
        summarize();
    end
    // main sequence
    initial begin
        @(negedge ref_clk);
        chk(32'(wdog_to), 32'(WDOG_LONG_CYC));
        chk({31'h0, mon_pwr}, 32'h0);
        chk({31'h0, trip_rsvd}, 32'h1);
        tick(1);
        rst_n <= 1'b1;
        por_n <= 1'b1;
        tick(REC_SHORT_CYC + 2);
        @(negedge ref_clk);
        chk({31'h0, rec}, 32'h1);
        wait_low();
        rd(A_ONE, ONE_RESET);
        rd(A_TWO, 8'h00);
        chk({31'h0, wdog_dis}, 32'h0);
        // clock enable low freezes the stop opcode decode
        ce <= 1'b0;
        opc <= 1'b1;
        tick(1);
        opc <= 1'b0;
        @(negedge ref_clk);
        chk({30'h0, stop_enter, illegal}, 32'h0);
        @(posedge ref_clk);
        ce <= 1'b1;
        stop_try(1'b0);
        // write without byte lane zero is dropped
        begin : no_lane
            logic [31:0] r;
            xfer(A_ONE, 1'b1, 8'hFF, 4'hE, r);
        end
        rd(A_ONE, ONE_RESET);
        wr(A_ONE, 8'hC6);
        rd(A_ONE, 8'hC6);
        chk(32'(wdog_to), 32'(WDOG_SHORT_CYC));
        chk({mon_pwr, mon_stop, one_used}, 32'h7);
        mreq <= 1'b1;
        wr(A_ONE, 8'h31);
        rd(A_ONE, 8'hC6);
        chk({31'h0, mon_rst}, 32'h1);
        stop_try(1'b1);
        wake_len(REC_SHORT_CYC);
        wr(8'h78, 8'hFF);
        rd(8'h78, 8'h00);
        rd(A_TWO, 8'h00);
        wr(A_TWO, 8'hFF);
        rd(A_TWO, 8'h7F);
        chk({31'h0, two_used}, 32'h1);
        chk({irc, xtal, pcu, pcl}, 32'hF);
        chk({31'h0, bypass}, 32'h1);
        bus_clock_select <= 1'b1;
        tick(2);
        chk({31'h0, bypass}, 32'h0);
        bus_clock_select <= 1'b0;
        rst(1'b0);
        rd(A_ONE, ONE_RESET);
        rd(A_TWO, 8'h06);
        wr(A_TWO, 8'h18);
        rd(A_TWO, 8'h1E);
        wr(A_ONE, 8'h23);
        tick(1);
        chk({mon_rst, mon_pwr, mon_stop}, 32'h2);
        chk({31'h0, wdog_dis}, 32'h1);
        wait_low();
        stop_try(1'b1);
        wake_len(LONG);
        // every trip code, each after its own power-on reset
        for (int c = 0; c < 4; c++) begin
            rst(1'b1);
            chk({31'h0, bypass}, 32'h0);
            wr(A_TWO, {5'h00, 2'(c), 1'b0});
            tick(1);
            chk({trip, trip_rsvd}, {29'h0, 2'(c), c == 0 || c == 3});
        end
        summarize();
    end
endmodule
